/* File: strap_mux_pkg.sv */
// constants and carrier types for the parallel port strap and pin mux block
// assumes a single core clock; all pin-side inputs are synchronised first
`default_nettype none
package strap_mux_pkg;
  // power and test register layout
  localparam int unsigned PTR_WIDTH     = 8;
  localparam int unsigned PTR_EXT_BIT   = 7;  // extended mode
  localparam int unsigned PTR_CLK_BIT   = 1;  // stop internal clocks
  localparam int unsigned PTR_OSC_BIT   = 2;  // stop crystal oscillator
  localparam logic [7:0]  PTR_RESET     = 8'h00;
  // function control register layout
  localparam int unsigned FCR_WIDTH     = 8;
  localparam int unsigned FCR_RATE_BIT  = 0;  // media sense pins drive rate
  localparam int unsigned FCR_SEL_BIT   = 2;  // shared input is the select
  localparam logic [7:0]  FCR_RESET     = 8'h00;
  // parallel data pins reused for the floppy drive
  localparam int unsigned PD_WIDTH      = 8;
  localparam int unsigned PD_RDATA_BIT  = 3;
  localparam int unsigned PD_SENSE0_BIT = 5;
  localparam int unsigned PD_SENSE1_BIT = 7;
  localparam logic [7:0]  PD_RESET      = 8'h00;
  // synchroniser depth
  localparam int unsigned SYNC_STAGES   = 2;

  // what the floppy side sees after the pin mux
  typedef struct packed {
    logic       read_data;      // raw serial read stream
    logic [1:0] media_sense;    // primary media sense inputs
    logic [1:0] extra_sense;    // media sense borrowed from data pins
    logic       second_drive;   // second-drive sense
  } floppy_sense_t;

  // power-down controls
  typedef struct packed {
    logic clocks_stopped;
    logic osc_stopped;
  } power_ctl_t;
endpackage : strap_mux_pkg
`default_nettype wire

/* File: pin_sync.sv */
// two-flop synchroniser bank for asynchronous pin inputs
// assumes nothing reads the first stage but the second stage
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock
  input  wire logic             core_clk,
  // pins and synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  // next values: no reset so straps are sampled while reset is held
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // register stages
  always_ff @(posedge core_clk) begin
    meta_reg <= meta_next;
    sync_out <= sync_next;
  end
endmodule : pin_sync
`default_nettype wire

/* File: strap_pin_mux.sv */
// parallel port strap sampling, power-down and printer/floppy pin mux
// assumes pins arrive asynchronously; register bits arrive as plain ports
//
// Operation
// - extended bit clear: direction follows reset-sampled direction strap.
// - output-enable strap low at reset sets the extended bit.
// - output-enable strap high leaves direction to the direction strap.
// - software writes to the extended bit override the strap after reset.
// - power-down pin stops clocks and/or oscillator per power bits.
// - control bit two set makes shared input the printer/floppy select.
// - select one routes pins to printer, zero routes them to floppy.
// - control bit two clear makes shared input the second-drive sense.
// - floppy routing turns two parallel data pins into extra media sense.
// - data pins move bytes both ways between peripheral and latch.
// - raw serial floppy read stream is accepted on the read-data input, or on pd3 under floppy routing.
// - media sense pins are inputs, or rate outputs when bit zero set.
`default_nettype none
module strap_pin_mux
  import strap_mux_pkg::*;
(
  // clock and master reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // strap and control pins
  input  wire logic                 direction_strap,
  input  wire logic                 output_enable_strap,
  input  wire logic                 power_down_pin,
  input  wire logic                 shared_select_pin,
  input  wire logic                 paper_out,
  input  wire logic                 read_strobe_n,
  input  wire logic                 disk_read_data_pin,
  // parallel data pins
  input  wire logic [PD_WIDTH-1:0]  parallel_data_in,
  output var  logic [PD_WIDTH-1:0]  parallel_data_out,
  output var  logic                 parallel_data_oe,
  // primary media sense pins
  input  wire logic [1:0]           media_sense_in,
  output var  logic [1:0]           media_sense_out,
  output var  logic                 media_sense_oe,
  // register writes and levels from the core
  input  wire logic                 ptr_wr_en,
  input  wire logic [PTR_WIDTH-1:0] ptr_wr_data,
  input  wire logic                 fcr_wr_en,
  input  wire logic [FCR_WIDTH-1:0] fcr_wr_data,
  input  wire logic                 data_wr_en,
  input  wire logic [PD_WIDTH-1:0]  data_wr_data,
  input  wire logic                 ext_direction_in,
  input  wire logic [1:0]           data_rate,
  // register and status views
  output var  logic [PTR_WIDTH-1:0] power_test_register,
  output var  logic [FCR_WIDTH-1:0] function_control_register,
  output var  logic [PD_WIDTH-1:0]  data_rd_data,
  output var  logic                 data_rd_valid,
  output var  logic                 paper_out_status,
  output var  logic                 direction_is_input,
  // pin mux results
  output var  logic                 printer_selected,
  output var  logic                 port_pin_multiplex_mode,
  output var  floppy_sense_t        floppy_sense,
  output var  power_ctl_t           power_ctl
);
  // synchronised pins, bundled into one bank
  localparam int unsigned NSYNC = 7 + 2 + PD_WIDTH;
  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] sync_pins;
  logic             dir_s;
  logic             oe_s;
  logic             power_down_pin_s;
  logic             sel_s;
  logic             nopaper_s;
  logic             rd_n_s;
  logic             rdata_s;
  logic [1:0]       msen_s;
  logic [PD_WIDTH-1:0] pd_s;

  assign raw_pins = {direction_strap, output_enable_strap, power_down_pin,
                     shared_select_pin, paper_out, read_strobe_n,
                     disk_read_data_pin, media_sense_in, parallel_data_in};

  pin_sync #(
    .WIDTH    (NSYNC)
  ) u_sync (
    .core_clk (core_clk),
    .async_in (raw_pins),
    .sync_out (sync_pins)
  );

  // unbundle the synchronised bank
  assign {dir_s, oe_s, power_down_pin_s, sel_s, nopaper_s, rd_n_s, rdata_s,
          msen_s, pd_s} = sync_pins;

  // ---------------------------------------------------------------
  // strap capture and configuration registers
  logic                 dir_strap_reg;
  logic                 dir_strap_next;
  logic [PTR_WIDTH-1:0] ptr_reg;
  logic [PTR_WIDTH-1:0] ptr_next;
  logic [FCR_WIDTH-1:0] fcr_reg;
  logic [FCR_WIDTH-1:0] fcr_next;

  // straps track the pins while reset is held, frozen once it lifts
  always_comb begin
    dir_strap_next = dir_strap_reg;
    ptr_next       = ptr_reg;
    fcr_next       = fcr_reg;
    if (reset) begin
      dir_strap_next        = dir_s;
      ptr_next              = PTR_RESET;
      ptr_next[PTR_EXT_BIT] = ~oe_s;
      fcr_next              = FCR_RESET;
    end else begin
      if (ptr_wr_en) begin
        ptr_next = ptr_wr_data;
      end
      if (fcr_wr_en) begin
        fcr_next = fcr_wr_data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    dir_strap_reg <= dir_strap_next;
    ptr_reg       <= ptr_next;
    fcr_reg       <= fcr_next;
  end

  // ---------------------------------------------------------------
  // data path: latch, direction and read capture
  logic [PD_WIDTH-1:0] latch_reg;
  logic [PD_WIDTH-1:0] latch_next;
  logic [PD_WIDTH-1:0] rd_data_reg;
  logic [PD_WIDTH-1:0] rd_data_next;
  logic                rd_valid_reg;
  logic                rd_valid_next;
  logic                rd_n_prev_reg;
  logic                rd_n_prev_next;
  logic                dir_in_reg;
  logic                dir_in_next;
  logic                oe_reg;
  logic                oe_next;
  logic                floppy_route;

  // floppy routing borrows the data pins, so the port never drives them
  assign floppy_route = fcr_reg[FCR_SEL_BIT] & ~sel_s;

  always_comb begin
    latch_next     = latch_reg;
    rd_data_next   = rd_data_reg;
    rd_valid_next  = 1'b0;
    rd_n_prev_next = rd_n_s;
    dir_in_next    = dir_in_reg;
    oe_next        = 1'b0;
    if (reset) begin
      latch_next     = PD_RESET;
      rd_data_next   = PD_RESET;
      rd_n_prev_next = 1'b1;
      dir_in_next    = 1'b0;
    end else begin
      if (data_wr_en) begin
        latch_next = data_wr_data;
      end
      // extended mode hands direction to software
      if (ptr_reg[PTR_EXT_BIT]) begin
        dir_in_next = ext_direction_in;
      end else begin
        dir_in_next = dir_strap_reg;
      end
      oe_next = ~dir_in_next & ~floppy_route;
      // falling read strobe samples pins, or the latch when driving
      if (rd_n_prev_reg && !rd_n_s) begin
        rd_data_next  = dir_in_reg ? pd_s : latch_reg;
        rd_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    latch_reg     <= latch_next;
    rd_data_reg   <= rd_data_next;
    rd_valid_reg  <= rd_valid_next;
    rd_n_prev_reg <= rd_n_prev_next;
    dir_in_reg    <= dir_in_next;
    oe_reg        <= oe_next;
  end

  // ---------------------------------------------------------------
  // pin mux, media sense and power-down
  floppy_sense_t fs_reg;
  floppy_sense_t fs_next;
  power_ctl_t    pwr_reg;
  power_ctl_t    pwr_next;
  logic          prn_reg;
  logic          prn_next;
  logic          ppm_reg;
  logic          ppm_next;
  logic          nopaper_reg;
  logic          nopaper_next;
  logic [1:0]    msen_out_reg;
  logic [1:0]    msen_out_next;
  logic          msen_oe_reg;
  logic          msen_oe_next;

  always_comb begin
    fs_next       = '0;
    pwr_next      = '0;
    prn_next      = 1'b1;
    ppm_next      = 1'b0;
    nopaper_next  = 1'b0;
    msen_out_next = 2'h0;
    msen_oe_next  = 1'b0;
    if (!reset) begin
      nopaper_next = nopaper_s;
      if (fcr_reg[FCR_SEL_BIT]) begin
        prn_next = sel_s;
        ppm_next = ~sel_s;
      end else begin
        fs_next.second_drive = sel_s;
      end
      // floppy routing: pd3 carries read data, pd5 and pd7 media sense
      if (floppy_route) begin
        fs_next.read_data      = pd_s[PD_RDATA_BIT];
        fs_next.extra_sense[0] = pd_s[PD_SENSE0_BIT];
        fs_next.extra_sense[1] = pd_s[PD_SENSE1_BIT];
      end else begin
        fs_next.read_data = rdata_s;
      end
      // pins turn into rate outputs; sensed values then read as zero
      if (fcr_reg[FCR_RATE_BIT]) begin
        msen_out_next = data_rate;
        msen_oe_next  = 1'b1;
      end else begin
        fs_next.media_sense = msen_s;
      end
      // stop requests only while the pin is held
      if (power_down_pin_s) begin
        pwr_next.clocks_stopped = ptr_reg[PTR_CLK_BIT];
        pwr_next.osc_stopped    = ptr_reg[PTR_OSC_BIT];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    fs_reg       <= fs_next;
    pwr_reg      <= pwr_next;
    prn_reg      <= prn_next;
    ppm_reg      <= ppm_next;
    nopaper_reg  <= nopaper_next;
    msen_out_reg <= msen_out_next;
    msen_oe_reg  <= msen_oe_next;
  end

  // outputs straight from flops
  assign parallel_data_out         = latch_reg;
  assign parallel_data_oe          = oe_reg;
  assign media_sense_out           = msen_out_reg;
  assign media_sense_oe            = msen_oe_reg;
  assign power_test_register       = ptr_reg;
  assign function_control_register = fcr_reg;
  assign data_rd_data              = rd_data_reg;
  assign data_rd_valid             = rd_valid_reg;
  assign paper_out_status          = nopaper_reg;
  assign direction_is_input        = dir_in_reg;
  assign printer_selected          = prn_reg;
  assign port_pin_multiplex_mode   = ppm_reg;
  assign floppy_sense              = fs_reg;
  assign power_ctl                 = pwr_reg;
endmodule : strap_pin_mux
`default_nettype wire

/* File: strap_pin_mux_chk.sv */
// checker for the strap and pin mux block, bound to its top module
// assumes synchronous reset and a two-stage pin synchroniser in front
`default_nettype none
module strap_pin_mux_chk
  import strap_mux_pkg::*;
(
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 reset,
  // pins
  input wire logic                 read_strobe_n,
  input wire logic                 power_down_pin,
  input wire logic                 shared_select_pin,
  input wire logic                 disk_read_data_pin,
  input wire logic [PD_WIDTH-1:0]  parallel_data_in,
  // register writes and levels
  input wire logic                 ptr_wr_en,
  input wire logic [PTR_WIDTH-1:0] ptr_wr_data,
  input wire logic                 fcr_wr_en,
  input wire logic [FCR_WIDTH-1:0] fcr_wr_data,
  input wire logic [1:0]           data_rate,
  // results
  input wire logic [PTR_WIDTH-1:0] power_test_register,
  input wire logic [FCR_WIDTH-1:0] function_control_register,
  input wire logic                 data_rd_valid,
  input wire logic [1:0]           media_sense_out,
  input wire logic                 media_sense_oe,
  input wire logic                 port_pin_multiplex_mode,
  input wire floppy_sense_t        floppy_sense,
  input wire power_ctl_t           power_ctl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // pin effects lag three samples: two sync stages plus the output flop
  sequence strobe_fall;
    $fell(read_strobe_n);
  endsequence
  sequence one_pulse;
    ##3 data_rd_valid ##1 !data_rd_valid;
  endsequence
  chk_read_pulse: assert property (strobe_fall |-> one_pulse)
    else $error("read strobe gave no single valid pulse");
  chk_ptr_write: assert property (ptr_wr_en |=>
    power_test_register == $past(ptr_wr_data))
    else $error("power test register missed a write");
  chk_fcr_write: assert property (fcr_wr_en |=>
    function_control_register == $past(fcr_wr_data))
    else $error("function control register missed a write");
  chk_rate_enable: assert property (
    media_sense_oe == $past(function_control_register[FCR_RATE_BIT]))
    else $error("media sense enable does not follow rate bit");
  chk_rate_value: assert property (media_sense_oe |->
    media_sense_out == $past(data_rate))
    else $error("media sense pins do not carry the rate");
  chk_power_stop: assert property (power_ctl == (
    $past(power_down_pin, 3) ? {$past(power_test_register[PTR_CLK_BIT]),
    $past(power_test_register[PTR_OSC_BIT])} : 2'h0))
    else $error("power down controls wrong");
  chk_floppy_route: assert property (port_pin_multiplex_mode ==
    ($past(function_control_register[FCR_SEL_BIT])
    && !$past(shared_select_pin, 3)))
    else $error("floppy routing wrong");
  // floppy sense outputs registered while reset was held read zero, so skip that edge
  chk_second_drive: assert property (!$past(reset) |->
    floppy_sense.second_drive ==
    (!$past(function_control_register[FCR_SEL_BIT])
    && $past(shared_select_pin, 3)))
    else $error("second drive sense wrong");
  chk_read_stream: assert property (!$past(reset) &&
    !port_pin_multiplex_mode |->
    floppy_sense.read_data == $past(disk_read_data_pin, 3))
    else $error("read stream not passed through");
  chk_extra_sense: assert property (port_pin_multiplex_mode |->
    floppy_sense.extra_sense == {$past(parallel_data_in[PD_SENSE1_BIT], 3),
    $past(parallel_data_in[PD_SENSE0_BIT], 3)})
    else $error("borrowed media sense wrong");
endmodule : strap_pin_mux_chk
bind strap_pin_mux strap_pin_mux_chk u_chk (.core_clk, .reset,
  .read_strobe_n, .power_down_pin, .shared_select_pin, .disk_read_data_pin,
  .parallel_data_in,
  .ptr_wr_en, .ptr_wr_data, .fcr_wr_en, .fcr_wr_data, .data_rate,
  .power_test_register, .function_control_register, .data_rd_valid,
  .media_sense_out, .media_sense_oe, .port_pin_multiplex_mode,
  .floppy_sense, .power_ctl);
`default_nettype wire

/* File: periph_model.sv */
// printer or floppy drive model on the far side of the data pins
// assumes the block's data enable is high while it drives the pins
`default_nettype none
module periph_model (
  // clock
  input  wire logic       core_clk,
  // block side of the shared data pins
  input  wire logic [7:0] dev_out,
  input  wire logic       dev_oe,
  // what the bench asks the peripheral to present
  input  wire logic [7:0] send_byte,
  input  wire logic       no_paper,
  // pin levels seen by the block
  output var  logic [7:0] pins,
  output var  logic       paper_out,
  output var  logic       read_stream
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase = 3'h0;
  // peripheral drives the lines only once the block has let go
  always_comb pins = dev_oe ? dev_out : send_byte;
  always_comb paper_out = no_paper;
  // raw unseparated read stream, a bit cell every four clocks
  always_ff @(posedge core_clk) phase <= phase + 3'h1;
  always_comb read_stream = phase[2];
endmodule : periph_model
`default_nettype wire

/* File: strap_pin_mux_tb.sv */
// self-checking bench for the strap and pin mux block
// assumes the partner model resolves the shared data pins
`default_nettype none
module strap_pin_mux_tb;
  import strap_mux_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, reset = 1'b1, direction_strap = 1'b0;
  logic output_enable_strap = 1'b1, power_down_pin = 1'b0;
  logic shared_select_pin = 1'b1, read_strobe_n = 1'b1, no_paper = 1'b0;
  logic ptr_wr_en = 1'b0, fcr_wr_en = 1'b0, data_wr_en = 1'b0;
  logic ext_direction_in = 1'b0, paper_out, disk_read_data_pin;
  logic [7:0] ptr_wr_data = 8'h00, fcr_wr_data = 8'h00, send_byte = 8'h00;
  logic [7:0] data_wr_data = 8'h00, parallel_data_in, parallel_data_out;
  logic [7:0] power_test_register, function_control_register, data_rd_data;
  logic [1:0] media_sense_in = 2'h0, data_rate = 2'h0, media_sense_out;
  logic parallel_data_oe, media_sense_oe, data_rd_valid, paper_out_status;
  logic direction_is_input, printer_selected, port_pin_multiplex_mode;
  floppy_sense_t floppy_sense;
  power_ctl_t    power_ctl;
  int failures = 0, n_compared = 0;
  always #2.5 core_clk = ~core_clk;
  strap_pin_mux u_dut (.core_clk, .reset, .direction_strap,
    .output_enable_strap, .power_down_pin, .shared_select_pin, .paper_out,
    .read_strobe_n, .disk_read_data_pin, .parallel_data_in,
    .parallel_data_out, .parallel_data_oe, .media_sense_in, .media_sense_out,
    .media_sense_oe, .ptr_wr_en, .ptr_wr_data, .fcr_wr_en, .fcr_wr_data,
    .data_wr_en, .data_wr_data, .ext_direction_in, .data_rate,
    .power_test_register, .function_control_register, .data_rd_data,
    .data_rd_valid, .paper_out_status, .direction_is_input,
    .printer_selected, .port_pin_multiplex_mode, .floppy_sense, .power_ctl);
  periph_model u_periph (.core_clk, .dev_out(parallel_data_out),
    .dev_oe(parallel_data_oe), .send_byte, .no_paper,
    .pins(parallel_data_in), .paper_out, .read_stream(disk_read_data_pin));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // sample one time unit past the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic to_fcr, input logic [7:0] d);
    @(posedge core_clk);
    ptr_wr_en   <= !to_fcr;
    fcr_wr_en   <= to_fcr;
    ptr_wr_data <= d;
    fcr_wr_data <= d;
    @(posedge core_clk);
    ptr_wr_en <= 1'b0;
    fcr_wr_en <= 1'b0;
    tick(2);
  endtask : wr
  // straps are sampled through reset, then held against pin changes
  task automatic do_reset(input logic d, input logic o);
    @(posedge core_clk);
    reset <= 1'b1;
    direction_strap <= d;
    output_enable_strap <= o;
    tick(16);
    @(posedge core_clk);
    reset <= 1'b0;
    direction_strap <= !d;
    tick(5);
    check(power_test_register, {!o, 7'h00});
    check(direction_is_input, o ? d : ext_direction_in);
  endtask : do_reset
  task automatic rd(input logic [7:0] exp);
    @(posedge core_clk);
    read_strobe_n <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      tick(1);
      if (data_rd_valid === 1'b1) break;
    end
    check(data_rd_valid, 1'b1);
    check(data_rd_data, exp);
    @(posedge core_clk);
    read_strobe_n <= 1'b1;
    tick(3);
  endtask : rd
  task automatic t_strap_ptr;
    for (int i = 0; i < 4; i++) do_reset(i[0], i[1]);
    // software takes over: extended bit set, software asks for output
    ext_direction_in <= 1'b0;
    wr(1'b0, 8'h80);
    check(direction_is_input, 1'b0);
    check(parallel_data_oe, 1'b1);
    wr(1'b0, 8'h00);
    check(direction_is_input, 1'b1);
    check(parallel_data_oe, 1'b0);
  endtask : t_strap_ptr
  task automatic t_power;
    for (int v = 2; v < 8; v += 2) begin
      wr(1'b0, v[7:0]);
      power_down_pin <= 1'b1;
      tick(5);
      check(power_ctl, {v[1], v[2]});
      power_down_pin <= 1'b0;
      tick(5);
      check(power_ctl, 2'h0);
    end
  endtask : t_power
  task automatic t_mux;
    wr(1'b1, 8'h04);
    send_byte <= 8'ha8;
    shared_select_pin <= 1'b0;
    tick(5);
    check(printer_selected, 1'b0);
    check(floppy_sense, 6'h26);
    send_byte <= 8'h20;
    shared_select_pin <= 1'b1;
    tick(5);
    check(port_pin_multiplex_mode, 1'b0);
    check(printer_selected, 1'b1);
    wr(1'b1, 8'h00);
    check(floppy_sense.second_drive, 1'b1);
  endtask : t_mux
  task automatic t_data_rate;
    do_reset(1'b0, 1'b1);
    data_wr_en <= 1'b1;
    data_wr_data <= 8'h3c;
    tick(1);
    data_wr_en <= 1'b0;
    tick(3);
    check(parallel_data_out, 8'h3c);
    rd(8'h3c);
    do_reset(1'b1, 1'b1);
    send_byte <= 8'ha5;
    rd(8'ha5);
    send_byte <= 8'h5a;
    rd(8'h5a);
    data_rate <= 2'h2;
    no_paper <= 1'b1;
    wr(1'b1, 8'h01);
    check({media_sense_oe, media_sense_out}, 3'h6);
    check(paper_out_status, 1'b1);
    media_sense_in <= 2'h1;
    wr(1'b1, 8'h00);
    tick(2);
    check({media_sense_oe, floppy_sense.media_sense}, 3'h1);
  endtask : t_data_rate
  task automatic summarize;
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // whole run is a few hundred cycles; twenty thousand means a hang
  initial begin
    #100000;
    failures++;
    summarize();
  end
  initial begin
    t_strap_ptr();
    t_power();
    t_mux();
    t_data_rate();
    summarize();
  end
endmodule : strap_pin_mux_tb
`default_nettype wire
